/* File: hdl/fbs_status_ctrl.sv */
// What this block does
// - ident mismatch at parameterization sets fault
// - data link fault sets fault flag
// - exchange size mismatch sets fault flag
// - valid response clears fault flag
// - alarm waiting follows pending alarm
// - diag waiting follows pending diagnostics
// - station mismatch when actual differs expected
// - checksum mismatch when mappings disagree
// - clear indicator low in bus clear
// - ack indicator low after last ack
// - alarm only on request rising edge
// - report station number of this node
// - report own mapping checksum
// - one outstanding alarm until acknowledged
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module fbs_status_ctrl
  import fbs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // fieldbus events from the protocol engine, one cycle pulses
  input wire logic ident_mismatch_evt,
  input wire logic link_fault_evt,
  input wire logic size_mismatch_evt,
  input wire logic valid_resp_evt,
  // fieldbus levels from the network side, asynchronous
  input wire logic alarm_pending_in,
  input wire logic diag_pending_in,
  input wire logic bus_clear_in,
  input wire logic [STN_W-1:0] actual_station,
  // master acknowledge of the raised alarm, one cycle pulse
  input wire logic alarm_ack_evt,
  // alarm notification towards the master
  output logic alarm_notify,
  output logic irq
);
  // synchronised network levels; the station word is taken as static, so a
  // change may show one cycle of mixed bits in the mismatch compare
  logic [STN_W+2:0] sync_q;

  fbs_sync #(.W(STN_W+3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .d({actual_station, bus_clear_in, diag_pending_in, alarm_pending_in}),
    .q(sync_q)
  );

  // whole block state
  typedef struct packed
  {
    logic fault;                  // node fault flag
    logic outstanding;            // alarm raised, not acknowledged
    logic ack_ind;                // alarm acknowledge indicator
    logic notify;                 // alarm notification pulse
    logic ctrl_upd;               // control word written this cycle
    logic [31:0] ctrl;            // host output control word
    logic [STN_W-1:0] cfg_stn;    // configured station of this node
    logic [CRC_W-1:0] cfg_crc;    // device mapping checksum
    logic [7:0] status;           // registered status bits
    logic [EV_W-1:0] ev_stat;     // sticky events
    logic [EV_W-1:0] ev_mask;     // interrupt mask
    logic irq;
    logic ack;
    logic [31:0] dat;
  } fbs_state_t;
  fbs_state_t st;
  fbs_state_t next_st;

  logic req_rise;

  // alarm request edge against previous control update
  fbs_edge u_edge (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .upd(st.ctrl_upd),
    .d(st.ctrl[C_ALARM_REQ]),
    .rise(req_rise)
  );

  // byte lane merge for writes
  function automatic logic [31:0] fbs_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  logic wb_req;
  logic [STN_W-1:0] exp_stn;
  logic [CRC_W-1:0] exp_crc;
  logic stn_mis;
  logic map_mis;
  logic [EV_W-1:0] ev_set;
  logic [31:0] wdat;
  logic [31:0] mask_wr; // mask register after the lane merge
  logic [31:0] cfg_wr; // config word after the lane merge

  // decode of request and host fields
  always_comb
  begin
    wb_req = wb_cyc_i && wb_stb_i && !st.ack;
    exp_stn = st.ctrl[C_STN_LSB +: STN_W];
    exp_crc = st.ctrl[C_CRC_LSB +: CRC_W];
    stn_mis = sync_q[STN_W+2:3] != exp_stn;
    map_mis = exp_crc != st.cfg_crc;
    wdat = fbs_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    mask_wr = fbs_merge({28'h000_0000, st.ev_mask}, wb_dat_i, wb_sel_i);
    cfg_wr = fbs_merge({st.cfg_crc, 8'h00, st.cfg_stn}, wb_dat_i, wb_sel_i);
  end

  // next state of the whole block
  always_comb
  begin
    next_st = st;
    ev_set = '0;
    if (ce)
    begin
      next_st.ack = wb_req;
      next_st.ctrl_upd = 1'b0;
      next_st.notify = 1'b0;
      // fault flag: set events win over the clearing response
      if (valid_resp_evt)
        next_st.fault = 1'b0;
      if (ident_mismatch_evt)
        next_st.fault = 1'b1;
      if (link_fault_evt)
        next_st.fault = 1'b1;
      if (size_mismatch_evt)
        next_st.fault = 1'b1;
      // alarm handshake with the master
      if (alarm_ack_evt && st.outstanding)
      begin
        next_st.outstanding = 1'b0;
        next_st.ack_ind = 1'b0;
        ev_set[E_ALARM_ACK] = 1'b1;
      end
      if (req_rise && !st.outstanding)
      begin
        next_st.outstanding = 1'b1;
        next_st.notify = 1'b1;
        next_st.ack_ind = 1'b1;
        ev_set[E_ALARM_SENT] = 1'b1;
      end
      ev_set[E_FAULT] = ident_mismatch_evt || link_fault_evt || size_mismatch_evt;
      ev_set[E_MISMATCH] = (stn_mis || map_mis) &&
                           !(st.status[B_STN_MIS] || st.status[B_MAP_MIS]);
      // live status word
      next_st.status = '0;
      next_st.status[B_FAULT] = next_st.fault;
      next_st.status[B_ALARM_WAIT] = sync_q[0];
      next_st.status[B_DIAG_WAIT] = sync_q[1];
      next_st.status[B_STN_MIS] = stn_mis;
      next_st.status[B_MAP_MIS] = map_mis;
      next_st.status[B_CLEAR_IND] = !sync_q[2];
      next_st.status[B_ACK_IND] = next_st.ack_ind;
      // register access
      next_st.dat = 32'h0000_0000;
      if (wb_req && wb_we_i)
      begin
        unique case (wb_adr_i)
          OFF_IRQ_STAT: next_st.ev_stat = st.ev_stat & ~wdat[EV_W-1:0];
          OFF_IRQ_MASK: next_st.ev_mask = mask_wr[EV_W-1:0];
          OFF_CTRL:
          begin
            next_st.ctrl = fbs_merge(st.ctrl, wb_dat_i, wb_sel_i);
            next_st.ctrl_upd = 1'b1;
          end
          OFF_CONFIG:
          begin
            next_st.cfg_stn = cfg_wr[STN_W-1:0];
            next_st.cfg_crc = cfg_wr[C_CRC_LSB +: CRC_W];
          end
          default: ;
        endcase
      end
      else if (wb_req)
      begin
        unique case (wb_adr_i)
          OFF_STATUS: next_st.dat = {24'h00_0000, st.status};
          OFF_IRQ_STAT: next_st.dat = {28'h000_0000, st.ev_stat};
          OFF_IRQ_MASK: next_st.dat = {28'h000_0000, st.ev_mask};
          OFF_CTRL: next_st.dat = st.ctrl;
          OFF_ECHO: next_st.dat = {st.cfg_crc, 8'h00, st.cfg_stn};
          OFF_CONFIG: next_st.dat = {st.cfg_crc, 8'h00, st.cfg_stn};
          default: next_st.dat = 32'h0000_0000;
        endcase
      end
      // set wins over the write-one clear
      next_st.ev_stat = next_st.ev_stat | ev_set;
      next_st.irq = |(next_st.ev_stat & next_st.ev_mask);
    end
  end

  // register all state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      // no alarm pending yet, so the ack indicator rests high
      st.ack_ind <= RST_STATUS[B_ACK_IND];
      st.status <= RST_STATUS;
    end
    else
      st <= next_st;
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign alarm_notify = st.notify;
  assign irq = st.irq;

  // fault set one cycle after a fault event
  property p_fault_set;
    @(posedge clk) disable iff (!resetn)
      (ce && (link_fault_evt || ident_mismatch_evt || size_mismatch_evt)) |=> st.fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not set");

  // fault cleared by a lone valid response
  property p_fault_clr;
    @(posedge clk) disable iff (!resetn)
      (ce && valid_resp_evt && !link_fault_evt && !ident_mismatch_evt &&
       !size_mismatch_evt) |=> !st.fault;
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared");

  // notify only when a rise met no outstanding alarm
  property p_notify_cause;
    @(posedge clk) disable iff (!resetn)
      st.notify && $past(ce) |-> $past(req_rise) && !$past(st.outstanding);
  endproperty
  a_notify_cause: assert property (p_notify_cause) else $error("spurious alarm");

  // no second alarm while one is outstanding
  property p_one_alarm;
    @(posedge clk) disable iff (!resetn)
      st.outstanding && $past(ce) |-> !st.notify || !$past(st.outstanding);
  endproperty
  a_one_alarm: assert property (p_one_alarm) else $error("second alarm raised");

  // ack indicator drops on acknowledge
  property p_ack_ind;
    @(posedge clk) disable iff (!resetn)
      (ce && alarm_ack_evt && st.outstanding && !req_rise) |=> !st.ack_ind && !st.status[B_ACK_IND];
  endproperty
  a_ack_ind: assert property (p_ack_ind) else $error("ack indicator stuck");

  // clear indicator inverts the synchronised level
  property p_clear;
    @(posedge clk) disable iff (!resetn)
      ce |=> st.status[B_CLEAR_IND] == !$past(sync_q[2]);
  endproperty
  a_clear: assert property (p_clear) else $error("clear indicator wrong");

  // station mismatch follows comparison
  property p_stn;
    @(posedge clk) disable iff (!resetn)
      ce |=> st.status[B_STN_MIS] == $past(stn_mis);
  endproperty
  a_stn: assert property (p_stn) else $error("station mismatch wrong");

  // wishbone ack is a single pulse
  property p_wb_ack;
    @(posedge clk) disable iff (!resetn)
      (ce && st.ack) |=> !st.ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack held");

  // ident mismatch shows in the status fault bit
  property p_ident;
    @(posedge clk) disable iff (!resetn)
      (ce && ident_mismatch_evt) |=> st.status[B_FAULT];
  endproperty
  a_ident: assert property (p_ident) else $error("ident fault not shown");

  // size mismatch shows in the status fault bit
  property p_size;
    @(posedge clk) disable iff (!resetn)
      (ce && size_mismatch_evt) |=> st.status[B_FAULT];
  endproperty
  a_size: assert property (p_size) else $error("size fault not shown");

  // alarm waiting follows the synchronised level
  property p_alarm_wait;
    @(posedge clk) disable iff (!resetn)
      ce |=> st.status[B_ALARM_WAIT] == $past(sync_q[0]);
  endproperty
  a_alarm_wait: assert property (p_alarm_wait) else $error("alarm waiting wrong");

  // diagnostics waiting follows the synchronised level
  property p_diag_wait;
    @(posedge clk) disable iff (!resetn)
      ce |=> st.status[B_DIAG_WAIT] == $past(sync_q[1]);
  endproperty
  a_diag_wait: assert property (p_diag_wait) else $error("diag waiting wrong");

  // checksum mismatch follows comparison
  property p_map;
    @(posedge clk) disable iff (!resetn)
      ce |=> st.status[B_MAP_MIS] == $past(map_mis);
  endproperty
  a_map: assert property (p_map) else $error("checksum mismatch wrong");

  // a raised alarm sets the ack indicator and stays outstanding
  property p_ack_raise;
    @(posedge clk) disable iff (!resetn)
      (ce && req_rise && !st.outstanding) |=> st.ack_ind && st.outstanding;
  endproperty
  a_ack_raise: assert property (p_ack_raise) else $error("raise not recorded");

  // the notification never lasts two enabled cycles
  property p_notify_pulse;
    @(posedge clk) disable iff (!resetn)
      (ce && st.notify) |=> !st.notify;
  endproperty
  a_notify_pulse: assert property (p_notify_pulse) else $error("alarm repeated");

  // echo read returns the held station and checksum
  property p_echo;
    @(posedge clk) disable iff (!resetn)
      (ce && wb_req && !wb_we_i && wb_adr_i == OFF_ECHO) |=>
        st.dat == {st.cfg_crc, 8'h00, st.cfg_stn};
  endproperty
  a_echo: assert property (p_echo) else $error("echo word wrong");

  // interrupt level matches the masked sticky events
  property p_irq;
    @(posedge clk) disable iff (!resetn)
      ce |=> st.irq == |(st.ev_stat & st.ev_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
endmodule
`default_nettype wire

/* File: hdl/fbs_pkg.sv */
package fbs_pkg;
  // widths of the status fields
  localparam int STN_W = 8;                 // station number width
  localparam int CRC_W = 16;                // mapping checksum width
  // wishbone register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00; // live status bits
  localparam logic [7:0] OFF_IRQ_STAT = 8'h04; // sticky event bits
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08; // interrupt mask
  localparam logic [7:0] OFF_CTRL = 8'h0C;   // host output control word
  localparam logic [7:0] OFF_ECHO = 8'h10;   // echoed station and checksum
  localparam logic [7:0] OFF_CONFIG = 8'h14; // configured station and checksum
  // status bit positions
  localparam int B_FAULT = 0;
  localparam int B_ALARM_WAIT = 1;
  localparam int B_DIAG_WAIT = 2;
  localparam int B_STN_MIS = 3;
  localparam int B_MAP_MIS = 4;
  localparam int B_CLEAR_IND = 5;
  localparam int B_ACK_IND = 6;
  // control word fields
  localparam int C_ALARM_REQ = 0;
  localparam int C_STN_LSB = 8;
  localparam int C_CRC_LSB = 16;
  // event bit positions
  localparam int E_FAULT = 0;
  localparam int E_ALARM_SENT = 1;
  localparam int E_ALARM_ACK = 2;
  localparam int E_MISMATCH = 3;
  localparam int EV_W = 4;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EV_W-1:0] RST_EV = 4'h0;
  localparam logic [7:0] RST_STATUS = 8'h60; // clear and ack indicators rest high
endpackage

/* File: hdl/fbs_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// two flop synchroniser for external level inputs
module fbs_sync
  import fbs_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // state: first and second stage
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fbs_sync_t;
  fbs_sync_t st;
  fbs_sync_t next_st;

  // shift the input along the chain
  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
    end
  end

  // register the chain
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.s2;
endmodule
`default_nettype wire

/* File: hdl/fbs_edge.sv */
`timescale 1ns/10ps
`default_nettype none
// rising edge detector against the value of the previous update
module fbs_edge
  import fbs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic upd,
  input wire logic d,
  output logic rise
);
  // state: held previous value and edge pulse
  typedef struct packed
  {
    logic prev;
    logic rise;
  } fbs_edge_t;
  fbs_edge_t st;
  fbs_edge_t next_st;

  // compare with the value of the last assembly update
  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      next_st.rise = 1'b0;
      if (upd)
      begin
        next_st.rise = d && !st.prev;
        next_st.prev = d;
      end
    end
  end

  // register edge state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign rise = st.rise;
endmodule
`default_nettype wire

/* File: bench/fbs_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: answers each raised alarm with one acknowledge pulse
module fbs_master_model
#(
  parameter int DLY = 3
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic alarm_notify,
  input wire logic hold,
  output logic alarm_ack_evt
);
  logic busy; // an alarm is waiting for our answer
  int cnt; // cycles since the alarm arrived
  // one ack per notification, after DLY cycles and once hold drops
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      cnt <= 0;
      alarm_ack_evt <= 1'b0;
    end
    else
    begin
      alarm_ack_evt <= 1'b0;
      if (alarm_notify === 1'b1)
      begin
        busy <= 1'b1;
        cnt <= 0;
      end
      else if (busy && !hold && cnt >= DLY)
      begin
        busy <= 1'b0;
        alarm_ack_evt <= 1'b1;
      end
      else if (busy)
        cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fbs_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, cyc = 0, stb = 0, we = 0, hold = 0;
  logic [7:0] adr = 8'h00, stn = 8'h00;
  logic [3:0] sel = 4'hf, ev = 4'h0;
  logic [31:0] dat = 32'h0000_0000, q;
  logic apend = 0, dpend = 0, bclr = 0;
  wire logic [31:0] rd;
  wire logic ack, note, irq, aack;
  int failures = 0, checks = 0, notes = 0, cyc_n = 0;
  fbs_status_ctrl dut (.clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .ident_mismatch_evt(ev[0]), .link_fault_evt(ev[1]),
    .size_mismatch_evt(ev[2]), .valid_resp_evt(ev[3]), .alarm_pending_in(apend),
    .diag_pending_in(dpend), .bus_clear_in(bclr), .actual_station(stn),
    .alarm_ack_evt(aack), .alarm_notify(note), .irq(irq));
  fbs_master_model mm (.clk(clk), .resetn(resetn), .alarm_notify(note), .hold(hold),
    .alarm_ack_evt(aack));
  // clock and run-time ceiling
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc_n++;
    if (note === 1'b1)
      notes++;
    if (cyc_n == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rd;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset();
    rdchk("status", OFF_STATUS, 32'h0000_0060);
    rdchk("mask", OFF_IRQ_MASK, 32'h0000_0000);
    rdchk("unmapped", 8'h1C, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_levels();
    @(posedge clk);
    apend <= 1; dpend <= 1; bclr <= 1;
    repeat (10) @(posedge clk);
    rdchk("levels", OFF_STATUS, 32'h0000_0046);
    @(posedge clk);
    apend <= 0; dpend <= 0; bclr <= 0;
    repeat (10) @(posedge clk);
    rdchk("idle", OFF_STATUS, 32'h0000_0060);
    $display("test levels done");
  endtask
  task automatic t_fault();
    wb(1, OFF_IRQ_STAT, 32'h0000_000F);
    wb(1, OFF_IRQ_MASK, 32'h0000_0001);
    for (int k = 0; k < 3; k++)
    begin
      pulse(4'h1 << k);
      rdchk("fault set", OFF_STATUS, 32'h0000_0061);
      chk("irq high", {31'h0, irq}, 32'h1);
      pulse(4'h8);
      rdchk("fault clr", OFF_STATUS, 32'h0000_0060);
      wb(1, OFF_IRQ_STAT, 32'h0000_0001);
      @(posedge clk);
      @(posedge clk);
      chk("irq low", {31'h0, irq}, 32'h0);
    end
    $display("test fault done");
  endtask
  task automatic t_mismatch();
    @(posedge clk);
    stn <= 8'h2A;
    wb(1, OFF_CONFIG, 32'hBEEF_002A);
    wb(1, OFF_CTRL, 32'hBEEF_2A00);
    repeat (10) @(posedge clk);
    rdchk("match", OFF_STATUS, 32'h0000_0060);
    rdchk("echo", OFF_ECHO, 32'hBEEF_002A);
    wb(1, OFF_CTRL, 32'hBEEF_2B00);
    repeat (4) @(posedge clk);
    rdchk("stn mis", OFF_STATUS, 32'h0000_0068);
    wb(1, OFF_CTRL, 32'h1234_2A00);
    repeat (4) @(posedge clk);
    rdchk("crc mis", OFF_STATUS, 32'h0000_0070);
    sel <= 4'h1;
    wb(1, OFF_CONFIG, 32'h0000_0011);
    sel <= 4'hf;
    rdchk("lane", OFF_ECHO, 32'hBEEF_0011);
    $display("test mismatch done");
  endtask
  task automatic t_alarm();
    hold <= 1;
    wb(1, OFF_IRQ_STAT, 32'h0000_000F);
    wb(1, OFF_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    chk("raised", notes, 1);
    rdchk("ack ind", OFF_STATUS, 32'h0000_0078);
    rdchk("sent evt", OFF_IRQ_STAT, 32'h0000_0002);
    wb(1, OFF_CTRL, 32'h0000_0000);
    wb(1, OFF_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    chk("one out", notes, 1);
    hold <= 0;
    repeat (10) @(posedge clk);
    rdchk("acked", OFF_STATUS, 32'h0000_0038);
    rdchk("acked evt", OFF_IRQ_STAT, 32'h0000_0006);
    wb(1, OFF_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    chk("level", notes, 1);
    wb(1, OFF_CTRL, 32'h0000_0000);
    wb(1, OFF_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    chk("again", notes, 2);
    $display("test alarm done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_levels();
    t_fault();
    t_mismatch();
    t_alarm();
    stop_test();
  end
endmodule
`default_nettype wire
